/* File: hdl/hbi_host_port.v */
// Purpose: pin-level host bus interface: ready/wait signalling, cycle
//          qualification, address decode, interrupt and strap capture
// Assumes: bus clock sampled by sys_clk; a host bus clock faster than
//          a quarter of sys_clk cannot be followed
// Notes:   register port answers reads one cycle after the strobe
//
// Operation
// - sync mode: falling sync ready marks ready
// - burst mode: sync ready low during waits
// - irq low while any unmasked status bit set
// - select when qualifier low and address matches
// - select is combinational from pins and the base register
// - async ready held low to stretch cycle
// - mode strap picks synchronous or asynchronous style
// - eeprom used only when its strap high
// - rising address strobe latches address, qualifier
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps

module hbi_host_port #(
	parameter WAITW = 4
) (
	input wire sys_clk,
	input wire resetn,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire bus_clk,
	input wire [11:0] host_address_high,
	input wire [2:0] host_address_low,
	input wire address_qualifier_n,
	input wire address_strobe_n,
	input wire read_strobe_n,
	input wire write_strobe_n,
	input wire command_cycle_n,
	input wire write_read_select,
	input wire ready_return_in_n,
	input wire sync_mode_strap,
	input wire eeprom_enable_strap,
	output reg sync_ready_out_n,
	output reg async_ready_out,
	output wire local_device_select_n,
	output wire irq_out_n,
	output wire eeprom_enable,
	output wire sync_mode,
	output wire burst_mode
);
`include "hbi_map.vh"

	localparam S_IDLE = 2'h0;
	localparam S_WAIT = 2'h1;
	localparam S_RDY = 2'h2;
	localparam A_IDLE = 2'h0;
	localparam A_WAIT = 2'h1;
	localparam A_HOLD = 2'h2;

	// address match against the base register
	function match;
		input [11:0] a;
		input [15:0] b;
		begin
			match = (a == b[`HBI_BASE_MSB:`HBI_BASE_LSB]);
		end
	endfunction

	reg [15:0] base_q, latch_q;
	reg [WAITW-1:0] wait_q, scnt_q, acnt_q;
	reg [`HBI_IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q;
	reg [1:0] settle_q, sst_q, ast_q;
	reg burst_sel_q, strap_sync_q, strap_eep_q, strap_done_q;
	reg bclk_prev_q, as_prev_q;
	reg ev_done_s, ev_done_a, ev_rdret;
	wire [24:0] pins_s;
	wire [14:0] addr_s;
	wire bclk_s, aq_s, as_s, rd_s, wr_s, cyc_s, wrs_s, rr_s;
	wire strap_sync_s, strap_eep_s;
	wire bclk_rise, as_rise, sel_s, start_s, ev_latch;
	wire sync_on, burst_on, async_on;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	hbi_sync2 #(
		.W(25)
	) u_sync (
		.clk(sys_clk),
		.resetn(resetn),
		.din({bus_clk, host_address_high, host_address_low,
			address_qualifier_n, address_strobe_n, read_strobe_n,
			write_strobe_n, command_cycle_n, write_read_select,
			ready_return_in_n, sync_mode_strap, eeprom_enable_strap}),
		.dout(pins_s)
	);

	assign bclk_s = pins_s[24];
	assign addr_s = pins_s[23:9];
	assign aq_s = pins_s[8];
	assign as_s = pins_s[7];
	assign rd_s = pins_s[6];
	assign wr_s = pins_s[5];
	assign cyc_s = pins_s[4];
	assign wrs_s = pins_s[3];
	assign rr_s = pins_s[2];
	assign strap_sync_s = pins_s[1];
	assign strap_eep_s = pins_s[0];

	// ****************************************************************
	// address decode
	// ****************************************************************
	// straight from the pins: a clocked path would add host latency
	assign local_device_select_n = ~(~address_qualifier_n &
		match(host_address_high, base_q));
	// synced copy drives the internal state machines
	assign sel_s = ~aq_s & match(addr_s[14:3], base_q);

	// ****************************************************************
	// strap capture after reset release
	// ****************************************************************
	// waits for the synchronisers to fill before taking the straps
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			settle_q <= 2'h0;
			strap_done_q <= 1'b0;
			strap_sync_q <= 1'b0;
			strap_eep_q <= 1'b0;
		end else if (!strap_done_q) begin
			if (settle_q == `HBI_STRAP_SETTLE) begin
				strap_done_q <= 1'b1;
				strap_sync_q <= strap_sync_s;
				strap_eep_q <= strap_eep_s;
			end else begin
				settle_q <= settle_q + 2'h1;
			end
		end
	end

	// low strap selects synchronous style, high the others
	assign sync_on = strap_done_q & ~strap_sync_q;
	assign burst_on = strap_done_q & strap_sync_q & burst_sel_q;
	assign async_on = strap_done_q & strap_sync_q & ~burst_sel_q;
	assign eeprom_enable = strap_done_q & strap_eep_q;
	assign sync_mode = sync_on;
	assign burst_mode = burst_on;

	// ****************************************************************
	// edge detection and address latch
	// ****************************************************************
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bclk_prev_q <= 1'b0;
			as_prev_q <= 1'b1;
			latch_q <= 16'h0000;
		end else begin
			bclk_prev_q <= bclk_s;
			as_prev_q <= as_s;
			if (as_rise)
				latch_q <= {aq_s, addr_s};
		end
	end

	assign bclk_rise = bclk_s & ~bclk_prev_q;
	assign as_rise = strap_done_q & as_s & ~as_prev_q; // no reset edge
	assign ev_latch = as_rise;

	// ****************************************************************
	// synchronous and burst ready machine
	// ****************************************************************
	// sync: cycle low starts command phase; burst: address strobe low
	assign start_s = sel_s & (sync_on ? ~cyc_s : (burst_on & ~as_s));

	// state, count and ready change only on a detected bus clock rising edge
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sst_q <= S_IDLE;
			scnt_q <= {WAITW{1'b0}};
			sync_ready_out_n <= 1'b1;
			ev_done_s <= 1'b0;
			ev_rdret <= 1'b0;
		end else begin
			ev_done_s <= 1'b0;
			ev_rdret <= 1'b0;
			if (bclk_rise) begin
				case (sst_q)
				S_IDLE: begin
					if (start_s) begin
						sst_q <= S_WAIT;
						scnt_q <= wait_q;
						// burst pulls low at once to hold the host
						sync_ready_out_n <= ~burst_on;
					end
				end
				S_WAIT: begin
					if (scnt_q == {WAITW{1'b0}}) begin
						sst_q <= S_RDY;
						// falling edge means ready in sync style
						sync_ready_out_n <= burst_on;
					end else begin
						scnt_q <= scnt_q - {{(WAITW-1){1'b0}}, 1'b1};
					end
				end
				S_RDY: begin
					// sync read flags the host's ready return as an event; cycle high (burst: address strobe high) ends the state
					if (sync_on & ~wrs_s & ~rr_s)
						ev_rdret <= 1'b1;
					if (sync_on ? cyc_s : as_s) begin
						sst_q <= S_IDLE;
						sync_ready_out_n <= 1'b1;
						ev_done_s <= 1'b1;
					end
				end
				default: begin
					sst_q <= S_IDLE;
					sync_ready_out_n <= 1'b1;
				end
				endcase
			end
		end
	end

	// ****************************************************************
	// asynchronous ready machine
	// ****************************************************************
	// counts sys_clk, not any host clock, so wait length is local
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ast_q <= A_IDLE;
			acnt_q <= {WAITW{1'b0}};
			async_ready_out <= 1'b1;
			ev_done_a <= 1'b0;
		end else begin
			ev_done_a <= 1'b0;
			case (ast_q)
			A_IDLE: begin
				if (async_on & sel_s & (~rd_s | ~wr_s)) begin
					ast_q <= A_WAIT;
					acnt_q <= wait_q;
					async_ready_out <= 1'b0;
				end
			end
			A_WAIT: begin
				if (acnt_q == {WAITW{1'b0}}) begin
					ast_q <= A_HOLD;
					async_ready_out <= 1'b1;
				end else begin
					acnt_q <= acnt_q - {{(WAITW-1){1'b0}}, 1'b1};
				end
			end
			A_HOLD: begin
				// back to idle only once both strobes released
				if (rd_s & wr_s) begin
					ast_q <= A_IDLE;
					ev_done_a <= 1'b1;
				end
			end
			default: begin
				ast_q <= A_IDLE;
				async_ready_out <= 1'b1;
			end
			endcase
		end
	end

	// ****************************************************************
	// interrupt status, read clears, set wins
	// ****************************************************************
	always @* begin
		irq_stat_d = irq_stat_q;
		if (reg_rd && reg_addr == `HBI_OFS_IRQ_STAT)
			irq_stat_d = {`HBI_IRQ_W{1'b0}};
		if (ev_done_s | ev_done_a)
			irq_stat_d[`HBI_IRQ_DONE] = 1'b1;
		if (ev_latch)
			irq_stat_d[`HBI_IRQ_LATCH] = 1'b1;
		if (ev_rdret)
			irq_stat_d[`HBI_IRQ_RDRET] = 1'b1;
	end

	// low while any unmasked status bit stands
	assign irq_out_n = ~|(irq_stat_q & irq_mask_q);

	// ****************************************************************
	// register writes
	// ****************************************************************
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			base_q <= `HBI_RST_BASE;
			wait_q <= `HBI_RST_WAIT;
			burst_sel_q <= `HBI_RST_CTRL;
			irq_mask_q <= `HBI_RST_IRQ;
			irq_stat_q <= `HBI_RST_IRQ;
		end else begin
			irq_stat_q <= irq_stat_d;
			if (reg_wr) begin
				case (reg_addr)
				`HBI_OFS_BASE: base_q <= reg_wdata[15:0];
				`HBI_OFS_WAIT: wait_q <= reg_wdata[WAITW-1:0];
				`HBI_OFS_CTRL: burst_sel_q <= reg_wdata[`HBI_CTRL_BURST];
				`HBI_OFS_IRQ_MASK: irq_mask_q <= reg_wdata[`HBI_IRQ_W-1:0];
				default: ;
				endcase
			end
		end
	end

	// ****************************************************************
	// register reads, one cycle later, zero elsewhere
	// ****************************************************************
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
			`HBI_OFS_BASE: reg_rdata <= {16'h0000, base_q};
			`HBI_OFS_WAIT: reg_rdata <= {{(32-WAITW){1'b0}}, wait_q};
			`HBI_OFS_CTRL: reg_rdata <= {31'h00000000, burst_sel_q};
			`HBI_OFS_IRQ_STAT: reg_rdata <= {29'h00000000, irq_stat_q};
			`HBI_OFS_IRQ_MASK: reg_rdata <= {29'h00000000, irq_mask_q};
			`HBI_OFS_CFG: reg_rdata <= {24'h000000, ast_q, sst_q,
				strap_done_q, burst_on, eeprom_enable, sync_on};
			`HBI_OFS_LATCH: reg_rdata <= {16'h0000, latch_q};
			default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule // hbi_host_port

/* File: hdl/hbi_map.vh */
// Purpose: register map, field positions and reset values of the host
//          bus interface block
// Assumes: 32-bit register port, byte offsets, one word per register
// Notes:   definitions only; included by bare name
`ifndef HBI_MAP_VH
`define HBI_MAP_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define HBI_OFS_BASE 8'h00
`define HBI_OFS_WAIT 8'h04
`define HBI_OFS_CTRL 8'h08
`define HBI_OFS_IRQ_STAT 8'h0C
`define HBI_OFS_IRQ_MASK 8'h10
`define HBI_OFS_CFG 8'h14
`define HBI_OFS_LATCH 8'h18

// ****************************************************************
// field positions
// ****************************************************************
`define HBI_BASE_MSB 15
`define HBI_BASE_LSB 4
`define HBI_CTRL_BURST 0
`define HBI_IRQ_DONE 0
`define HBI_IRQ_LATCH 1
`define HBI_IRQ_RDRET 2
`define HBI_IRQ_W 3
`define HBI_CFG_SYNC 0
`define HBI_CFG_EEPROM 1
`define HBI_CFG_BURST 2
`define HBI_CFG_VALID 3
`define HBI_LATCH_QUAL 15

// ****************************************************************
// reset values and counts
// ****************************************************************
`define HBI_RST_BASE 16'h0300
`define HBI_RST_WAIT 4'h2
`define HBI_RST_CTRL 1'h0
`define HBI_RST_IRQ 3'h0
`define HBI_STRAP_SETTLE 2'h3

`endif

/* File: hdl/hbi_sync2.v */
// Purpose: two-stage synchroniser for a bundle of pin inputs
// Assumes: each bit is an independent level; no bus coherence
// Notes:   the first stage is read only by the second stage
`timescale 1ns/100ps

module hbi_sync2 #(
	parameter W = 1
) (
	input wire clk,
	input wire resetn,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// ****************************************************************
	// two flops, reset to zero
	// ****************************************************************
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end

	assign dout = sync_q;

endmodule // hbi_sync2

/* File: dv/hbi_host_port_properties.sv */
// Purpose: pin and register port assertions for the host port
// Assumes: wait count at reset value; straps steady near release
// Notes:   bound to every host port instance
`timescale 1ns/100ps
// ****************************************************************
// checker
// ****************************************************************
module hbi_host_port_chk (
	input wire sys_clk,
	input wire resetn,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [11:0] host_address_high,
	input wire address_qualifier_n,
	input wire sync_mode_strap,
	input wire eeprom_enable_strap,
	input wire sync_ready_out_n,
	input wire async_ready_out,
	input wire local_device_select_n,
	input wire irq_out_n,
	input wire eeprom_enable,
	input wire sync_mode,
	input wire burst_mode
);
	reg [3:0] age_q;
	reg mask_w_q;
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// age since release; irq cannot fire before any mask write
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			age_q <= 4'h0;
			mask_w_q <= 1'b0;
		end else begin
			if (age_q != 4'hF)
				age_q <= age_q + 4'h1;
			if (reg_wr && reg_addr == 8'h10)
				mask_w_q <= 1'b1;
		end
	end
	sequence s_async_ready_out_wait;
		!async_ready_out [*3] ##1 async_ready_out;
	endsequence
	a_select_qual: assert property (
		!local_device_select_n |-> !address_qualifier_n)
		else $error("select active with qualifier high");
	a_select_comb: assert property (
		$changed(local_device_select_n) |-> $changed(address_qualifier_n)
		|| $changed(host_address_high) || $past(reg_wr))
		else $error("select moved without a cause");
	a_irq_masked: assert property (!mask_w_q |-> irq_out_n)
		else $error("irq with all sources masked");
	a_async_ready_out_len: assert property ($fell(async_ready_out) |-> s_async_ready_out_wait)
		else $error("async wait length wrong");
	a_async_ready_out_mode: assert property (
		$fell(async_ready_out) |-> !sync_mode && !burst_mode)
		else $error("async wait outside async mode");
	a_srdy_mode: assert property (
		$fell(sync_ready_out_n) |-> sync_mode || burst_mode)
		else $error("sync ready in async mode");
	a_mode_capture: assert property (age_q == 4'h8 |->
		sync_mode == !sync_mode_strap && eeprom_enable == eeprom_enable_strap)
		else $error("straps not captured");
	a_mode_fixed: assert property (age_q > 4'h8 |->
		$stable(sync_mode) && $stable(eeprom_enable))
		else $error("mode changed after capture");
endmodule // hbi_host_port_chk

bind hbi_host_port hbi_host_port_chk u_chk (.sys_clk, .resetn, .reg_addr,
	.reg_wr, .host_address_high, .address_qualifier_n, .sync_mode_strap,
	.eeprom_enable_strap, .sync_ready_out_n, .async_ready_out,
	.local_device_select_n, .irq_out_n, .eeprom_enable, .sync_mode,
	.burst_mode);

/* File: dv/hbi_host_model.sv */
// Purpose: host bus master driving the host port pins
// Assumes: 400 ns bus clock, parked low unless enabled
// Notes:   ready return kept asserted, as unused hosts must
`timescale 1ns/100ps
// ****************************************************************
// host model
// ****************************************************************
module hbi_host_model (
	input wire sys_clk,
	input wire run_clk,
	input wire sync_ready_out_n,
	input wire async_ready_out,
	output reg bus_clk,
	output reg [11:0] host_address_high,
	output reg [2:0] host_address_low,
	output reg address_qualifier_n,
	output reg address_strobe_n,
	output reg read_strobe_n,
	output reg write_strobe_n,
	output reg command_cycle_n,
	output reg write_read_select,
	output reg ready_return_in_n
);
	// idle bus
	initial begin
		bus_clk = 1'b0;
		host_address_high = 12'h000;
		host_address_low = 3'h0;
		address_qualifier_n = 1'b1;
		address_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		command_cycle_n = 1'b1;
		write_read_select = 1'b0;
		ready_return_in_n = 1'b0;
	end
	// slow clock, far under the limit; parked low in async mode
	always begin
		#200;
		bus_clk = run_clk & ~bus_clk;
	end
	task set_addr(input [11:0] a, input q);
		begin
			@(posedge sys_clk);
			host_address_high <= a;
			address_qualifier_n <= q;
			#1;
		end
	endtask
	// n: bus clock rises until ready falls, 0 on timeout
	task sync_read(input [11:0] a, output integer n);
		begin
			n = 0;
			set_addr(a, 1'b0);
			write_read_select <= 1'b0;
			@(posedge bus_clk);
			command_cycle_n <= 1'b0;
			while (sync_ready_out_n && n < 16) begin
				@(posedge bus_clk);
				n = n + 1;
			end
			if (sync_ready_out_n)
				n = 0;
			command_cycle_n <= 1'b1;
			@(posedge bus_clk);
			address_qualifier_n <= 1'b1;
		end
	endtask
	// n: bus clock rises with sync ready low, 0 if it never fell
	task burst_read(input [11:0] a, output integer n);
		begin
			n = 0;
			set_addr(a, 1'b0);
			command_cycle_n <= 1'b1;
			@(posedge bus_clk);
			address_strobe_n <= 1'b0;
			@(posedge bus_clk);
			while (!sync_ready_out_n && n < 16) begin
				@(posedge bus_clk);
				n = n + 1;
			end
			address_strobe_n <= 1'b1;
			@(posedge bus_clk);
			address_qualifier_n <= 1'b1;
		end
	endtask
	// lo: sys_clk cycles seen with async ready low; w picks the strobe
	task async_cycle(input [11:0] a, input w, output integer lo);
		integer i;
		begin
			lo = 0;
			set_addr(a, 1'b0);
			if (w)
				write_strobe_n <= 1'b0;
			else
				read_strobe_n <= 1'b0;
			for (i = 0; i < 40; i = i + 1) begin
				@(posedge sys_clk);
				#1;
				if (!async_ready_out)
					lo = lo + 1;
				else if (lo > 0)
					i = 40;
			end
			read_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
			address_qualifier_n <= 1'b1;
		end
	endtask
	task strobe_addr(input [11:0] a, input [2:0] b);
		begin
			set_addr(a, 1'b0);
			host_address_low <= b;
			address_strobe_n <= 1'b0;
			repeat (4) @(posedge sys_clk);
			address_strobe_n <= 1'b1;
			repeat (4) @(posedge sys_clk);
			address_qualifier_n <= 1'b1;
		end
	endtask
endmodule // hbi_host_model

/* File: dv/tb_host_bus_interface_signalling.sv */
// Purpose: self-checking bench for the host port
// Assumes: 20 MHz sys_clk, wait count left at reset value
// Notes:   straps take effect only through a fresh reset; t_sync moves the pins after capture
`timescale 1ns/100ps
// ****************************************************************
// bench top
// ****************************************************************
module tb_host_bus_interface_signalling;
	reg sys_clk, resetn, reg_wr, reg_rd, run_clk;
	reg sync_mode_strap, eeprom_enable_strap;
	reg [7:0] reg_addr;
	reg [31:0] reg_wdata, d;
	wire [31:0] reg_rdata;
	wire bus_clk, address_qualifier_n, address_strobe_n, read_strobe_n;
	wire write_strobe_n, command_cycle_n, write_read_select;
	wire ready_return_in_n, sync_ready_out_n, async_ready_out;
	wire local_device_select_n, irq_out_n, eeprom_enable, sync_mode;
	wire burst_mode;
	wire [11:0] host_address_high;
	wire [2:0] host_address_low;
	integer err_count = 0, check_count = 0, n;
	hbi_host_port DUT (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .bus_clk, .host_address_high, .host_address_low,
		.address_qualifier_n, .address_strobe_n, .read_strobe_n,
		.write_strobe_n, .command_cycle_n, .write_read_select,
		.ready_return_in_n, .sync_mode_strap, .eeprom_enable_strap,
		.sync_ready_out_n, .async_ready_out, .local_device_select_n,
		.irq_out_n, .eeprom_enable, .sync_mode, .burst_mode);
	hbi_host_model host (.sys_clk, .run_clk, .sync_ready_out_n,
		.async_ready_out, .bus_clk, .host_address_high, .host_address_low,
		.address_qualifier_n, .address_strobe_n, .read_strobe_n,
		.write_strobe_n, .command_cycle_n, .write_read_select,
		.ready_return_in_n);
	task chk(input [31:0] got, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1'b1;
			@(posedge sys_clk);
			reg_wr <= 1'b0;
		end
	endtask
	// data stands only in the cycle after the strobe
	task rd(input [7:0] a);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge sys_clk);
			reg_rd <= 1'b0;
			#1 d = reg_rdata;
		end
	endtask
	task do_reset(input sm, input ee);
		begin
			@(posedge sys_clk);
			resetn <= 1'b0;
			sync_mode_strap <= sm;
			eeprom_enable_strap <= ee;
			run_clk <= !sm;
			repeat (16) @(posedge sys_clk);
			resetn <= 1'b1;
			repeat (10) @(posedge sys_clk);
		end
	endtask
	task t_async;
		begin
			do_reset(1'b1, 1'b1);
			rd(8'h14);
			chk(d[3:0], 4'hA);
			rd(8'h00);
			chk(d[15:0], 16'h0300);
			rd(8'h1C);
			chk(d, 32'h0);
			rd(8'h0C);
			chk(d, 32'h0);
			wr(8'h10, 32'h1);
			host.async_cycle(12'h030, 1'b0, n);
			chk(n, 3);
			repeat (6) @(posedge sys_clk);
			chk(irq_out_n, 1'b0);
			rd(8'h0C);
			chk(d[0], 1'b1);
			chk(irq_out_n, 1'b1);
			host.async_cycle(12'h030, 1'b1, n);
			chk(n, 3);
			host.strobe_addr(12'hABC, 3'h5);
			rd(8'h18);
			chk(d[15:0], {1'b0, 12'hABC, 3'h5});
			wr(8'h08, 32'h1);
			rd(8'h14);
			chk({d[2], burst_mode}, 2'b11);
			$display("test async done");
		end
	endtask
	task t_select;
		begin
			host.set_addr(12'h030, 1'b0);
			chk(local_device_select_n, 1'b0);
			host.set_addr(12'h030, 1'b1);
			chk(local_device_select_n, 1'b1);
			host.set_addr(12'h031, 1'b0);
			chk(local_device_select_n, 1'b1);
			wr(8'h00, 32'h1230);
			host.set_addr(12'h123, 1'b0);
			chk(local_device_select_n, 1'b0);
			host.set_addr(12'h123, 1'b1);
			$display("test select done");
		end
	endtask
	// burst style still selected; base left at 0x1230 by the select test
	task t_burst;
		begin
			run_clk <= 1'b1;
			rd(8'h0C);
			host.burst_read(12'h123, n);
			chk(n, 3);
			repeat (3) @(posedge bus_clk);
			chk(sync_ready_out_n, 1'b1);
			rd(8'h0C);
			chk(d[2:0], 3'h3);
			run_clk <= 1'b0;
			$display("test burst done");
		end
	endtask
	task t_sync;
		begin
			do_reset(1'b0, 1'b0);
			sync_mode_strap <= 1'b1;
			eeprom_enable_strap <= 1'b1;
			host.sync_read(12'h030, n);
			chk(n > 2 && n < 9, 1'b1);
			repeat (3) @(posedge bus_clk);
			chk(sync_ready_out_n, 1'b1);
			rd(8'h0C);
			chk(d[2:0], 3'h5);
			rd(8'h14);
			chk(d[3:0], 4'h9);
			$display("test sync done");
		end
	endtask
	task summarize;
		begin
			$display("checks %0d mismatches %0d", check_count, err_count);
			if (err_count == 0 && check_count > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// bound on the whole run; a hang counts as a failure
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count = err_count + 1;
		$display("[ERR] %0t run timed out got %h exp %h", $time, 1'b0, 1'b1);
		summarize;
	end
	initial begin
		resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		t_async;
		t_select;
		t_burst;
		t_sync;
		summarize;
	end
endmodule // tb_host_bus_interface_signalling
